// file: hdl/fts_sequencer.v
// fts_sequencer.v: trip logic, range select, health, test cycle and recorder
// of the flux data processor. assumes one 250 MHz clock, AHB-Lite master,
// pin inputs asynchronous, the Modbus stack outside reading over the bus.
`default_nettype none
module fts_sequencer (
    input  wire        i_clk_sys,
    input  wire        i_sys_rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        i_operate_position,
    input  wire        i_test_mode,
    input  wire        i_remote_mode,
    input  wire        i_remote_trip_rst,
    input  wire [3:0]  i_remote_range,
    input  wire        i_remote_range_man,
    input  wire        i_watchdog_ok,
    output reg         o_power_alarm,
    output reg         o_power_warn,
    output reg         o_period_alarm,
    output reg         o_period_warn,
    output reg         o_overlap_fault,
    output reg         o_elec_fault,
    output reg         o_health_ok_indicator,
    output reg         o_detector_level_test_gen,
    output reg         o_discriminator_test_gen,
    output reg         o_ac_amp_test_gen,
    output reg         o_current_test_gen,
    output reg  [3:0]  o_lin_range
);
`include "fts_regs.vh"
    // =======================================================
    // pin synchronisers
    reg [7:0]  pin_s1_q;
    reg [7:0]  pin_s2_q;
    always @(posedge i_clk_sys) begin
        pin_s1_q <= {i_remote_range_man, i_remote_range, i_remote_trip_rst,
                     i_watchdog_ok, i_operate_position};
        pin_s2_q <= pin_s1_q;
    end
    reg [1:0] misc_s1_q;
    reg [1:0] misc_s2_q;
    always @(posedge i_clk_sys) begin
        misc_s1_q <= {i_remote_mode, i_test_mode};
        misc_s2_q <= misc_s1_q;
    end
    wire operate_s   = pin_s2_q[0];
    wire wdog_s      = pin_s2_q[1];
    wire rtrip_s     = pin_s2_q[2];
    wire [3:0] rrng_s = pin_s2_q[6:3];
    wire rman_s      = pin_s2_q[7];
    wire test_s      = misc_s2_q[0];
    wire remote_s    = misc_s2_q[1];

    // =======================================================
    // AHB-Lite slave, zero wait states
    reg        ph_q;
    reg        ph_wr_q;
    reg [7:0]  ph_addr_q;
    reg [31:0] ctrl_q;
    reg [15:0] power_q;
    reg [15:0] period_q;
    reg [15:0] ival_q;
    reg [15:0] step_q;
    reg [`FTS_REC_AW-1:0] rd_addr_q;
    wire acc = hsel & hready & htrans[1];
    wire wr_now = ph_q & ph_wr_q;
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ph_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ph_q <= acc;
            ph_wr_q <= acc & hwrite;
            if (acc) ph_addr_q <= haddr[7:0];
        end
    end

    // software writes; trip reset is self-clearing
    wire trip_rst_sw = wr_now & (ph_addr_q == `FTS_CTRL) & hwdata[`FTS_C_TRIP_RST];
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctrl_q <= 32'h0000_0010;
            power_q <= 16'h0000;
            period_q <= 16'hFFFF;
            ival_q <= `FTS_IVAL_RST;
            step_q <= `FTS_STEP_MS;
            rd_addr_q <= {`FTS_REC_AW{1'b0}};
        end else begin
            ctrl_q[`FTS_C_SAMPLE] <= 1'b0;
            if (wr_now) begin
                case (ph_addr_q)
                    `FTS_CTRL:     ctrl_q <= {hwdata[31:1], 1'b0};
                    `FTS_POWER:    power_q <= hwdata[15:0];
                    `FTS_PERIOD:   period_q <= hwdata[15:0];
                    // clamp keeps interval inside 1 ms to 1 min
                    `FTS_REC_IVAL: ival_q <= (hwdata[15:0] < `FTS_IVAL_MIN_MS) ? 16'h0001 :
                                   (hwdata[15:0] > `FTS_IVAL_MAX_MS) ? 16'hEA60 : hwdata[15:0];
                    `FTS_TEST:     step_q <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
                    `FTS_REC_ADDR: rd_addr_q <= hwdata[`FTS_REC_AW-1:0];
                    default:       ctrl_q <= ctrl_q;
                endcase
            end
        end
    end
    wire sample = ctrl_q[`FTS_C_SAMPLE];

    // =======================================================
    // setpoint comparison and latched trips
    wire [3:0] cond;
    reg        smp_d1_q;
    fts_limit_check u_limit (
        .i_clk_sys    (i_clk_sys),
        .i_sys_rst    (i_sys_rst),
        .i_sample     (sample),
        .i_power      (power_q),
        .i_period     (period_q[14:0] == 15'h0 ? 16'hFFFF : {1'b0, period_q[14:0]}),
        .i_period_pos (~period_q[15]),
        .o_cond       (cond)
    );
    always @(posedge i_clk_sys) smp_d1_q <= i_sys_rst ? 1'b0 : sample;
    wire trip_rst = trip_rst_sw | (remote_s & rtrip_s);
    reg [3:0] trip_q;
    reg       ovl_q;
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            trip_q <= 4'h0;
            ovl_q <= 1'b0;
        end else begin
            // new condition wins over reset in the same cycle
            trip_q <= (trip_q & {4{~trip_rst}}) | (cond & {4{operate_s & smp_d1_q}});
            if (sample & ctrl_q[`FTS_C_OVL_FAIL]) ovl_q <= 1'b1;
            else if (trip_rst) ovl_q <= 1'b0;
        end
    end
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_power_alarm <= 1'b0;
            o_power_warn <= 1'b0;
            o_period_alarm <= 1'b0;
            o_period_warn <= 1'b0;
            o_overlap_fault <= 1'b0;
        end else begin
            o_power_alarm <= trip_q[0] & operate_s;
            o_power_warn <= trip_q[1] & operate_s;
            o_period_alarm <= trip_q[2] & operate_s;
            o_period_warn <= trip_q[3] & operate_s;
            o_overlap_fault <= ovl_q;
        end
    end

    // =======================================================
    // range select and log power
    reg [3:0]  auto_rng_q;
    reg [15:0] log_q;
    integer k;
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            auto_rng_q <= 4'h0;
            log_q <= 16'h0000;
            o_lin_range <= 4'h0;
        end else begin
            if (sample) begin
                // auto range: one range per bit of the power word
                auto_rng_q <= 4'h0;
                for (k = 0; k < 16; k = k + 1)
                    if (power_q[k]) auto_rng_q <= k[3:0];
                // log power: single scale, no range switch
                log_q <= {8'h00, 4'h0, auto_rng_q};
            end
            if (remote_s & rman_s) o_lin_range <= rrng_s;
            else if (ctrl_q[`FTS_C_RANGE_MAN]) o_lin_range <= ctrl_q[`FTS_C_RANGE_LSB+3:`FTS_C_RANGE_LSB];
            else o_lin_range <= auto_rng_q;
        end
    end

    // =======================================================
    // health output
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) o_health_ok_indicator <= 1'b0;
        else o_health_ok_indicator <= wdog_s & ctrl_q[`FTS_C_PROG_OK] &
                                      ~ctrl_q[`FTS_C_SELF_FAIL];
    end

    // =======================================================
    // millisecond tick
    reg [17:0] div_q;
    wire ms_tick = (div_q == `FTS_TICK_CYC - 1);
    always @(posedge i_clk_sys) begin
        if (i_sys_rst | ms_tick) div_q <= 18'd0;
        else div_q <= div_q + 18'd1;
    end
    reg [31:0] time_q;
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) time_q <= 32'h0;
        else if (ms_tick) time_q <= time_q + 32'h1;
    end

    // =======================================================
    // automatic test cycle, one pass per entry into test mode
    localparam T_IDLE = 3'd0, T_G0 = 3'd1, T_G1 = 3'd2, T_G2 = 3'd3, T_G3 = 3'd4,
               T_DONE = 3'd5;
    reg [2:0]  tst_q;
    reg [15:0] tcnt_q;
    reg        test_d1_q;
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tst_q <= T_IDLE;
            tcnt_q <= 16'h0;
            test_d1_q <= 1'b0;
            o_elec_fault <= 1'b0;
        end else begin
            test_d1_q <= test_s;
            if (tst_q != T_IDLE && tst_q != T_DONE && ms_tick) tcnt_q <= tcnt_q + 16'h1;
            // check failures reported during test steps
            if ((tst_q != T_IDLE) && (tst_q != T_DONE) && ctrl_q[`FTS_C_CHK_FAIL])
                o_elec_fault <= 1'b1;
            else if (trip_rst) o_elec_fault <= 1'b0;
            case (tst_q)
                T_IDLE: if (test_s & ~test_d1_q) begin
                    tst_q <= T_G0;
                    tcnt_q <= 16'h0;
                end
                // leaving test mode aborts, generators run in test mode whether or not in operate position
                T_G0, T_G1, T_G2, T_G3: if (~test_s) tst_q <= T_IDLE;
                else if (tcnt_q >= step_q) begin
                    tst_q <= tst_q + 3'd1;
                    tcnt_q <= 16'h0;
                end
                T_DONE: if (~test_s) tst_q <= T_IDLE;
                default: tst_q <= T_IDLE;
            endcase
        end
    end
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_detector_level_test_gen <= 1'b0;
            o_discriminator_test_gen <= 1'b0;
            o_ac_amp_test_gen <= 1'b0;
            o_current_test_gen <= 1'b0;
        end else begin
            o_detector_level_test_gen <= (tst_q == T_G0);
            o_discriminator_test_gen <= (tst_q == T_G1);
            o_ac_amp_test_gen <= (tst_q == T_G2);
            o_current_test_gen <= (tst_q == T_G3);
        end
    end

    // =======================================================
    // recorder: circular buffer with a protected window after an alarm
    reg [31:0] mem [0:`FTS_REC_DEPTH-1];
    reg [`FTS_REC_AW-1:0] wp_q;
    reg [`FTS_REC_AW-1:0] prot_lo_q;
    reg        prot_q;
    reg [31:0] rcnt_q;
    reg [31:0] ev_ms_q;
    reg        ev_q;
    reg [3:0]  alm_prev_q;
    wire [3:0] alm_now = {o_period_warn, o_period_alarm, o_power_warn, o_power_alarm};
    wire       alm_chg = (alm_now != alm_prev_q);
    wire       any_alm = |alm_now;
    // event schedule of sample intervals
    wire [31:0] ival_ms = ~ev_q ? {16'h0, ival_q} :
                          (any_alm | (ev_ms_q < `FTS_FAST_WIN_MS)) ? `FTS_FAST_MS :
                          (ev_ms_q < `FTS_FAST_WIN_MS + `FTS_MID_WIN_MS) ? `FTS_MID_MS :
                          `FTS_SLOW_MS;
    wire pre_ev = any_alm & ~ev_q;
    wire rec_due = ms_tick & (rcnt_q + 32'h1 >= (pre_ev ? `FTS_FAST_MS : ival_ms));
    // writes stall when the next slot is the protected alarm history
    wire wp_blocked = prot_q & ((wp_q + 1'b1) == prot_lo_q);
    wire rec_wr = (rec_due | alm_chg) & ~wp_blocked;
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wp_q <= {`FTS_REC_AW{1'b0}};
            prot_lo_q <= {`FTS_REC_AW{1'b0}};
            prot_q <= 1'b0;
            rcnt_q <= 32'h0;
            ev_ms_q <= 32'h0;
            ev_q <= 1'b0;
            alm_prev_q <= 4'h0;
        end else begin
            alm_prev_q <= alm_now;
            if (ms_tick) rcnt_q <= rec_due ? 32'h0 : rcnt_q + 32'h1;
            if (any_alm & ~ev_q) begin
                ev_q <= 1'b1;
                ev_ms_q <= 32'h0;
                prot_q <= 1'b1;
                // keep pre-event history behind the write pointer
                prot_lo_q <= wp_q - 10'd100;
            end else if (ev_q & ms_tick) begin
                if (ev_ms_q >= `FTS_FAST_WIN_MS + `FTS_MID_WIN_MS + `FTS_SLOW_WIN_MS)
                    ev_q <= 1'b0;
                else ev_ms_q <= ev_ms_q + 32'h1;
            end
            if (wr_now & (ph_addr_q == `FTS_CTRL) & hwdata[`FTS_C_UNPROT] & ~pre_ev)
                prot_q <= 1'b0;
            if (rec_wr) wp_q <= wp_q + 1'b1;
        end
    end
    // alarm change entries carry a timestamp and a marker bit
    always @(posedge i_clk_sys) begin
        if (rec_wr)
            mem[wp_q] <= alm_chg ? {1'b1, 3'h0, alm_now, time_q[23:0]} :
                                   {1'b0, power_q[14:0], period_q};
    end
    reg [31:0] mem_rd_q;
    always @(posedge i_clk_sys) mem_rd_q <= mem[rd_addr_q];

    // =======================================================
    // read mux: host queries only answered, never initiated
    reg [31:0] rd_d;
    always @* begin
        case (haddr[7:0])
            `FTS_CTRL:      rd_d = ctrl_q;
            `FTS_STATUS:    rd_d = {23'h0, (tst_q != T_IDLE && tst_q != T_DONE), operate_s,
                                    o_health_ok_indicator, o_elec_fault, o_overlap_fault,
                                    o_period_warn, o_period_alarm, o_power_warn, o_power_alarm};
            `FTS_POWER:     rd_d = {16'h0, power_q};
            `FTS_PERIOD:    rd_d = {16'h0, period_q};
            `FTS_LIN_RANGE: rd_d = {28'h0, o_lin_range};
            `FTS_LOG_POWER: rd_d = {16'h0, log_q};
            `FTS_REC_IVAL:  rd_d = {16'h0, ival_q};
            `FTS_TEST:      rd_d = {13'h0, tst_q, step_q};
            `FTS_REC_STAT:  rd_d = {15'h0, prot_q, ev_q, 5'h0, wp_q};
            `FTS_REC_ADDR:  rd_d = {22'h0, rd_addr_q};
            `FTS_REC_DATA:  rd_d = mem_rd_q;
            `FTS_TIME:      rd_d = time_q;
            default:        rd_d = 32'h0;
        endcase
    end
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) hrdata <= 32'h0;
        else if (acc & ~hwrite) hrdata <= rd_d;
        else hrdata <= hrdata;
    end
endmodule
`default_nettype wire

// file: common/fts_regs.vh
// fts_regs.vh: register map, field positions, reset values and timing counts
// of the flux trip and test sequencer. definitions only.
`ifndef FTS_REGS_VH
`define FTS_REGS_VH
// register byte offsets
`define FTS_CTRL        8'h00
`define FTS_STATUS      8'h04
`define FTS_POWER       8'h08
`define FTS_PERIOD      8'h0C
`define FTS_LIN_RANGE   8'h10
`define FTS_LOG_POWER   8'h14
`define FTS_REC_IVAL    8'h18
`define FTS_TEST        8'h1C
`define FTS_REC_STAT    8'h20
`define FTS_REC_ADDR    8'h24
`define FTS_REC_DATA    8'h28
`define FTS_TIME        8'h2C
// ctrl fields
`define FTS_C_TRIP_RST  0
`define FTS_C_RANGE_MAN 1
`define FTS_C_SAMPLE    2
`define FTS_C_OVL_FAIL  3
`define FTS_C_PROG_OK   4
`define FTS_C_SELF_FAIL 5
`define FTS_C_CHK_FAIL  6
`define FTS_C_UNPROT    7
`define FTS_C_RANGE_LSB 8
// status fields
`define FTS_S_PWR_ALM   0
`define FTS_S_PWR_WRN   1
`define FTS_S_PER_ALM   2
`define FTS_S_PER_WRN   3
`define FTS_S_OVL_FLT   4
`define FTS_S_ELEC_FLT  5
`define FTS_S_HEALTH    6
`define FTS_S_OPERATE   7
`define FTS_S_TESTING   8
// setpoints: power in 0.1 % of nominal, period in 0.1 s
`define FTS_PWR_ALARM_SP    16'd1200
`define FTS_PWR_HIGH_SP     16'd1100
`define FTS_PWR_LOW_SP      16'd100
`define FTS_PER_ALARM_SP    16'd100
`define FTS_PER_WARN_SP     16'd200
// timing: one tick per millisecond at 250 MHz
`define FTS_CLK_MHZ         250
`define FTS_TICK_US         1000
`define FTS_TICK_CYC        (`FTS_CLK_MHZ * `FTS_TICK_US)
`define FTS_IVAL_MIN_MS     1
`define FTS_IVAL_MAX_MS     60000
`define FTS_IVAL_RST        16'd1000
`define FTS_FAST_MS         100
`define FTS_FAST_WIN_MS     10000
`define FTS_MID_MS          1000
`define FTS_MID_WIN_MS      100000
`define FTS_SLOW_MS         10000
`define FTS_SLOW_WIN_MS     1000000
`define FTS_STEP_MS         16'd500
`define FTS_REC_DEPTH       1024
`define FTS_REC_AW          10
`endif

// file: hdl/fts_limit_check.v
// fts_limit_check.v: compares one power and one period sample against the
// five setpoints. assumes samples stable while i_sample is high.
`default_nettype none
module fts_limit_check (
    input  wire        i_clk_sys,
    input  wire        i_sys_rst,
    input  wire        i_sample,
    input  wire [15:0] i_power,
    input  wire [15:0] i_period,
    input  wire        i_period_pos,
    output reg  [3:0]  o_cond
);
`include "fts_regs.vh"
    // =======================================================
    // setpoint compare, bit order: pwr alarm, pwr warn, per alarm, per warn
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_cond <= 4'h0;
        end else if (i_sample) begin
            o_cond[0] <= i_power > `FTS_PWR_ALARM_SP;
            o_cond[1] <= (i_power > `FTS_PWR_HIGH_SP) | (i_power < `FTS_PWR_LOW_SP);
            // negative period (falling flux) never trips
            o_cond[2] <= i_period_pos & (i_period < `FTS_PER_ALARM_SP);
            o_cond[3] <= i_period_pos & (i_period < `FTS_PER_WARN_SP);
        end
    end
endmodule
`default_nettype wire

// file: verif/fts_props_properties.sv
// fts_props_properties.sv: port-level checks of the trip and test sequencer.
// assumes one clock, synchronous active-high reset, inputs settled for cycles.
`default_nettype none
module fts_props (
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        i_operate_position,
    input wire logic        i_test_mode,
    input wire logic        i_remote_mode,
    input wire logic [3:0]  i_remote_range,
    input wire logic        i_remote_range_man,
    input wire logic        i_watchdog_ok,
    input wire logic        o_power_alarm,
    input wire logic        o_power_warn,
    input wire logic        o_period_alarm,
    input wire logic        o_period_warn,
    input wire logic        o_health_ok_indicator,
    input wire logic        o_detector_level_test_gen,
    input wire logic        o_discriminator_test_gen,
    input wire logic        o_ac_amp_test_gen,
    input wire logic        o_current_test_gen,
    input wire logic [3:0]  o_lin_range
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    logic [3:0] gens;
    assign gens = {o_detector_level_test_gen, o_discriminator_test_gen,
                   o_ac_amp_test_gen, o_current_test_gen};
    a_trips_need_operate: assert property ((!i_operate_position)[*4] |->
        !(o_power_alarm || o_power_warn || o_period_alarm || o_period_warn))
        else $error("trip output active outside operate position");
    a_health_drops: assert property ((!i_watchdog_ok)[*4] |-> !o_health_ok_indicator)
        else $error("health output high while watchdog reports fault");
    a_power_alarm_warn: assert property (o_power_alarm |-> o_power_warn)
        else $error("power alarm without power warning");
    a_period_alarm_warn: assert property (o_period_alarm |-> o_period_warn)
        else $error("period alarm without period warning");
    a_bus_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_zero_wait: assert property (hsel && hready && htrans[1] |=> hreadyout)
        else $error("transfer answered with wait state");
    a_one_test_gen: assert property ($onehot0(gens))
        else $error("more than one test generator active");
    a_gens_idle: assert property ((!i_test_mode)[*5] |-> gens == 4'h0)
        else $error("test generator active outside test mode");
    a_remote_range: assert property ((i_remote_mode && i_remote_range_man
        && $stable(i_remote_range))[*6] |-> o_lin_range == i_remote_range)
        else $error("linear range does not follow remote selection");
    cover property (o_power_alarm && o_period_alarm);
endmodule
`default_nettype wire

// file: verif/fts_safety_model.sv
// fts_safety_model.sv: plant safety logic stand-in that latches trip events.
// assumes trip inputs are plain digital levels in the system clock domain.
`default_nettype none
module fts_safety_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic [3:0] i_trips,
    output var  logic [7:0] o_trip_events
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // edge counter, counts each cycle with any fresh trip as one plant event
    logic [3:0] prev_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            prev_q        <= 4'h0;
            o_trip_events <= 8'h00;
        end else begin
            prev_q <= i_trips;
            if (|(i_trips & ~prev_q)) begin
                o_trip_events <= o_trip_events + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// testbench.sv: directed scenarios for the trip and test sequencer.
// assumes zero-wait AHB-Lite slave and the register map of fts_regs.vh.
`include "fts_regs.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 0, i_sys_rst = 1, hsel = 0, hwrite = 0, i_operate_position = 1;
    logic i_test_mode = 0, i_remote_mode = 0, i_remote_trip_rst = 0;
    logic i_remote_range_man = 0, i_watchdog_ok = 1, hready, hresp, hreadyout;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  i_remote_range = 0, o_lin_range, trips;
    logic [7:0]  events;
    logic        pa, pw, ya, yw, ovl, efl, hok, g0, g1, g2, g3;
    int n_fail = 0, n_checks = 0, cyc = 0;
    assign hready = hreadyout;
    assign trips  = {pa, pw, ya, yw};
    initial forever #2 i_clk_sys = ~i_clk_sys;
    fts_sequencer u_dut (.i_clk_sys, .i_sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .i_operate_position, .i_test_mode,
        .i_remote_mode, .i_remote_trip_rst, .i_remote_range, .i_remote_range_man,
        .i_watchdog_ok, .o_power_alarm(pa), .o_power_warn(pw), .o_period_alarm(ya),
        .o_period_warn(yw), .o_overlap_fault(ovl), .o_elec_fault(efl),
        .o_health_ok_indicator(hok), .o_detector_level_test_gen(g0),
        .o_discriminator_test_gen(g1), .o_ac_amp_test_gen(g2), .o_current_test_gen(g3),
        .o_lin_range);
    fts_safety_model u_safety (.i_clk_sys, .i_sys_rst, .i_trips(trips),
        .o_trip_events(events));
    // ==========================================
    // reporting and timeout
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin // generous, all scenarios together need under a thousand
            n_fail++;
            final_report();
        end
    end
    // ==========================================
    // bus tasks, master holds each phase until hready is seen high
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        hsel <= 1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
        do @(posedge i_clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge i_clk_sys); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 0;
    endtask
    task automatic sample(input logic [31:0] pwr, input logic [31:0] per);
        bus(1, `FTS_POWER, pwr);
        bus(1, `FTS_PERIOD, per);
        bus(1, `FTS_CTRL, 32'h0000_0014); // program ok kept high with the strobe
    endtask
    task automatic wait_trips(input logic [3:0] exp);
        int i;
        for (i = 0; i < 40 && trips !== exp; i++) @(posedge i_clk_sys);
        chk(trips, exp);
    endtask
    task automatic settle();
        repeat (20) @(posedge i_clk_sys);
    endtask
    // ==========================================
    // scenarios
    task automatic t_power();
        sample(32'd1200, 32'd500); wait_trips(4'h4);
        sample(32'd1201, 32'd500); wait_trips(4'hC);
        bus(0, `FTS_POWER, 32'h0);
        chk(rd, 32'd1201);
        bus(0, `FTS_STATUS, 32'h0);
        chk(rd, 32'h0000_00C3);
        sample(32'd500, 32'd500);  settle(); chk(trips, 4'hC);
        chk(events, 8'h02);
        @(posedge i_clk_sys); i_remote_mode <= 1; i_remote_trip_rst <= 1;
        settle(); i_remote_trip_rst <= 0; wait_trips(4'h0);
        sample(32'd99, 32'd500);   wait_trips(4'h4);
        bus(1, `FTS_CTRL, 32'h0000_0011); wait_trips(4'h0);
    endtask
    task automatic t_period();
        sample(32'd500, 32'd200);  settle(); chk(trips, 4'h0);
        sample(32'd500, 32'd199);  wait_trips(4'h1);
        sample(32'd500, 32'd99);   wait_trips(4'h3);
        bus(1, `FTS_CTRL, 32'h0000_0011); wait_trips(4'h0);
    endtask
    task automatic t_faults();
        bus(1, `FTS_POWER, 32'd500);
        bus(1, `FTS_PERIOD, 32'd500);
        bus(1, `FTS_CTRL, 32'h0000_001C); settle(); chk(ovl, 1'b1);
        bus(1, `FTS_CTRL, 32'h0000_0030); settle(); chk(hok, 1'b0);
        bus(1, `FTS_CTRL, 32'h0000_0010);
        settle();
        chk(hok, 1'b1);
        @(posedge i_clk_sys); i_watchdog_ok <= 0; settle(); chk(hok, 1'b0);
        i_watchdog_ok <= 1;
        @(posedge i_clk_sys); i_operate_position <= 0;
        sample(32'd1300, 32'd50); settle(); chk(trips, 4'h0);
        i_operate_position <= 1;
        bus(0, 32'h0000_0040, 32'h0); chk(hresp, 1'b0);
        chk(rd, 32'h0);
    endtask
    task automatic t_range();
        int r;
        bus(1, `FTS_CTRL, 32'h0000_0512);
        settle();
        chk(o_lin_range, 4'h5);
        i_remote_mode <= 1;
        i_remote_range_man <= 1;
        for (r = 0; r < 16; r++) begin
            i_remote_range <= r[3:0];
            settle();
            chk(o_lin_range, r[3:0]);
        end
    endtask
    task automatic t_test();
        int i;
        @(posedge i_clk_sys); i_test_mode <= 1;
        for (i = 0; i < 1000 && g0 !== 1'b1; i++) @(posedge i_clk_sys);
        chk({g0, g1, g2, g3}, 4'h8);
        bus(1, `FTS_CTRL, 32'h0000_0050);
        settle();
        chk(efl, 1'b1);
        bus(0, `FTS_STATUS, 32'h0);
        chk(rd, 32'h0000_01F0);
    endtask
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_sys_rst <= 0;
        bus(1, `FTS_CTRL, 32'h0000_0010);
        t_power();
        t_period();
        t_faults();
        t_range();
        t_test();
        final_report();
    end
endmodule
bind fts_sequencer fts_props u_props (.i_clk_sys, .i_sys_rst, .hsel, .htrans, .hready,
    .hreadyout, .hresp, .i_operate_position, .i_test_mode, .i_remote_mode, .i_remote_range,
    .i_remote_range_man, .i_watchdog_ok, .o_power_alarm, .o_power_warn, .o_period_alarm,
    .o_period_warn, .o_health_ok_indicator, .o_detector_level_test_gen,
    .o_discriminator_test_gen, .o_ac_amp_test_gen, .o_current_test_gen, .o_lin_range);
`default_nettype wire
